//--- logic/lsc_led_serial_ctrl.sv
// Serial control core of a multi-display LED driver: two-wire write-only slave,
// holding and active level registers, display gating and pump mode logic.
// Assumes SCL_CLK_IN is the master's bus clock and all other pins are asynchronous.
module lsc_led_serial_ctrl
  import lsc_pkg::*;
#(
  parameter int unsigned DROP_DELAY_CYC = DROP_DELAY_DEF
) (
  input  wire logic                   CLK_IN,
  input  wire logic                   NRST_IN,
  input  wire logic                   SCL_CLK_IN,
  input  wire logic                   SDA_IN,
  output logic                        SDA_DATA_OUT,
  output logic                        SDA_OE_OUT,
  input  wire logic                   DISPLAY_EN_IN,
  input  wire logic                   CAM_SEL_IN,
  input  wire logic                   OVERTEMP_IN,
  input  wire logic                   REF_FAULT_IN,
  input  wire logic [N_SOURCES-1:0]   DROPOUT_IN,
  output logic [7:0]                  MAIN_LEVEL_OUT,
  output logic [7:0]                  SUB_LEVEL_OUT,
  output logic [NIB_W-1:0]            RED_LEVEL_OUT,
  output logic [NIB_W-1:0]            GREEN_LEVEL_OUT,
  output logic [NIB_W-1:0]            BLUE_LEVEL_OUT,
  output logic [NIB_W-1:0]            CAM_LEVEL_OUT,
  output logic [AUX_N-1:0][7:0]       AUX_LEVEL_OUT,
  output logic                        MAIN_EN_OUT,
  output logic                        SUB_EN_OUT,
  output logic                        RED_EN_OUT,
  output logic                        GREEN_EN_OUT,
  output logic                        BLUE_EN_OUT,
  output logic                        CAM_EN_OUT,
  output logic                        AUX_EN_OUT,
  output logic                        PUMP_EN_OUT,
  output logic                        SHUTDOWN_OUT,
  output lsc_pump_t                   PUMP_MODE_OUT
);

  localparam int CW = $clog2(DROP_DELAY_CYC + 1);
  localparam logic [CW-1:0] DROP_LAST = CW'(DROP_DELAY_CYC - 1);

  typedef struct packed {
    logic [N_PINS-1:0]    pin_s1;
    logic [N_PINS-1:0]    pin_s2;
    logic [N_PINS-1:0]    pin_prev;
    logic [N_SOURCES-1:0] drop_s1;
    logic [N_SOURCES-1:0] drop_s2;
    logic [2:0]           tog_s;
    logic                 start_hold;
    logic [2:0]           sub;
    logic                 mid;
    logic                 pending;
    logic [7:1][7:0]      hold;
    logic [7:1][7:0]      act;
    logic [CW-1:0]        drop_cnt;
    lsc_pump_t            mode;
    logic [NIB_W-1:0]     cam_nib;
    logic [AUX_N-1:0][7:0] aux_lvl;
    logic [6:0]           en;  // main, sub, red, green, blue, cam, aux
    logic                 shutdown;
    logic                 pump_en;
  } lsc_clk_t;

  typedef struct packed {
    logic [6:0]  shift;
    logic [3:0]  bit_cnt;
    lsc_kind_t   kind;
    logic [7:0]  byte_q;
    lsc_kind_t   byte_kind;
    logic        ack_pend;
  } lsc_link_t;

  lsc_clk_t  c, next_c;
  lsc_link_t l, next_l;
  logic      byte_tog, ack_drive, link_rst_n;
  logic      scl_h, start_det, stop_det, byte_ev, fault, load, lvl_chg, cam_fall;
  logic      any_drop, step, fire;
  logic [7:0] opts;
  logic [7:0] link_full;

  // Routed level of one auxiliary output, in the width of the widest bank
  function automatic logic [7:0] aux_route(input logic [1:0] sel,
                                           input logic [NIB_W-1:0] aux_nib,
                                           input logic [7:0] main_lvl,
                                           input logic [7:0] sub_lvl,
                                           input logic [NIB_W-1:0] cam_nib);
    logic [7:0] r;
    r = {4'h0, aux_nib};
    unique case (sel)
      AUXSRC_AUX:  r = {4'h0, aux_nib};
      AUXSRC_MAIN: r = main_lvl;
      AUXSRC_SEC:  r = sub_lvl;
      AUXSRC_CAM:  r = {4'h0, cam_nib};
    endcase
    return r;
  endfunction

  // A START seen in the system domain holds the link logic in reset until SCL falls
  assign link_rst_n = NRST_IN & ~c.start_hold;
  assign link_full  = {l.shift, SDA_IN};
  // Answer the own address with the write bit, then every byte until next START
  assign fire = (l.bit_cnt == LAST_BIT) &&
                ((l.kind == LK_ADDR) ? (link_full == {SLAVE_ADDR, WRITE_BIT})
                                     : (l.kind != LK_IDLE));

  // Bit shifting MSB first and the address, sub-address, data byte order
  always_comb begin
    next_l = l;
    if (l.bit_cnt == ACK_BIT) begin
      next_l.bit_cnt  = 4'h0;
      next_l.ack_pend = 1'b0;
      unique case (l.kind)
        LK_ADDR: next_l.kind = l.ack_pend ? LK_SUB : LK_IDLE;
        LK_SUB:  next_l.kind = LK_DATA;
        LK_DATA: next_l.kind = LK_SUB;
        LK_IDLE: next_l.kind = LK_IDLE;
      endcase
    end else begin
      next_l.shift   = link_full[6:0];
      next_l.bit_cnt = l.bit_cnt + 4'h1;
      if (l.bit_cnt == LAST_BIT) begin
        next_l.ack_pend = fire;
        if (fire) begin
          next_l.byte_q    = link_full;
          next_l.byte_kind = l.kind;
        end
      end
    end
  end

  always_ff @(posedge SCL_CLK_IN or negedge link_rst_n) begin
    if (!link_rst_n) begin
      l <= '{kind: LK_ADDR, byte_kind: LK_ADDR, default: '0};
    end else begin
      l <= next_l;
    end
  end

  // Toggle survives a START reset so the far side never sees a false event
  always_ff @(posedge SCL_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      byte_tog <= 1'b0;
    end else if (fire) begin
      byte_tog <= ~byte_tog;
    end
  end

  // Acknowledge low across the ninth clock; the pin is never driven otherwise
  always_ff @(negedge SCL_CLK_IN or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ack_drive <= 1'b0;
    end else begin
      ack_drive <= (l.bit_cnt == ACK_BIT) && l.ack_pend;
    end
  end

  assign SDA_OE_OUT   = ack_drive;
  assign SDA_DATA_OUT = 1'b0;  // Open drain: only ever pulls low

  // Bus conditions, byte events and fault pins, all through the synchronisers
  assign scl_h     = c.pin_s2[P_SCL] & c.pin_prev[P_SCL];
  assign start_det = scl_h & c.pin_prev[P_SDA] & ~c.pin_s2[P_SDA];
  assign stop_det  = scl_h & ~c.pin_prev[P_SDA] & c.pin_s2[P_SDA];
  assign byte_ev   = c.tog_s[1] ^ c.tog_s[2];
  assign fault     = c.pin_s2[P_OT] | c.pin_s2[P_RF];
  assign opts      = c.act[SUB_OPTIONS];
  // A STOP in the middle of an address or sub-address is ignored
  assign load      = stop_det & c.pending & ~c.mid;
  assign lvl_chg   = c.hold[SUB_CAMERA:SUB_RED_GREEN] != c.act[SUB_CAMERA:SUB_RED_GREEN];
  assign cam_fall  = c.pin_prev[P_CAM] & ~c.pin_s2[P_CAM];
  assign any_drop  = ~c.shutdown & |(c.drop_s2 &
                     (opts[OPT_DROP_MASK] ? ~DROP_MASKABLE : {N_SOURCES{1'b1}}));
  assign step      = any_drop && (c.drop_cnt == DROP_LAST);

  // Synchronisers, byte capture, register load, display gating and pump mode
  always_comb begin
    logic [NIB_W-1:0] red, green, blue, aux_nib, cam_nib;
    logic [7:0]       main_lvl, sub_lvl, aux_sel;
    logic             target, en_pin;
    logic [6:0]       en;
    red      = c.act[SUB_RED_GREEN][LO_NIB +: NIB_W];
    green    = c.act[SUB_RED_GREEN][HI_NIB +: NIB_W];
    blue     = c.act[SUB_BLUE_AUX][LO_NIB +: NIB_W];
    aux_nib  = c.act[SUB_BLUE_AUX][HI_NIB +: NIB_W];
    main_lvl = c.act[SUB_MAIN];
    sub_lvl  = c.act[SUB_SECONDARY];
    aux_sel  = c.act[SUB_AUX_SEL];
    target   = opts[OPT_TARGET];
    en_pin   = c.pin_s2[P_EN];
    cam_nib  = (opts[OPT_CAM_OVR] || c.pin_s2[P_CAM]) ?
               c.act[SUB_CAMERA][HI_NIB +: NIB_W] : c.act[SUB_CAMERA][LO_NIB +: NIB_W];
    en       = 7'h00;
    next_c   = c;

    next_c.pin_s1   = {SCL_CLK_IN, SDA_IN, OVERTEMP_IN, REF_FAULT_IN, CAM_SEL_IN,
                       DISPLAY_EN_IN};
    next_c.pin_s2   = c.pin_s1;
    next_c.pin_prev = c.pin_s2;
    next_c.drop_s1  = DROPOUT_IN;
    next_c.drop_s2  = c.drop_s1;
    next_c.tog_s    = {c.tog_s[1:0], byte_tog};

    // START holds the link in reset only while SCL is still high
    if (start_det) begin
      next_c.start_hold = 1'b1;
    end else if (!c.pin_s2[P_SCL]) begin
      next_c.start_hold = 1'b0;
    end

    // Byte fields are stable in the link registers once the toggle arrives
    if (byte_ev) begin
      unique case (l.byte_kind)
        LK_ADDR: next_c.mid = 1'b1;
        LK_SUB: begin
          next_c.sub = l.byte_q[2:0];
          next_c.mid = 1'b1;
        end
        LK_DATA: begin
          if (c.sub != SUB_NONE) begin
            next_c.hold[c.sub] = l.byte_q;
          end
          next_c.mid     = 1'b0;
          next_c.pending = 1'b1;
        end
        LK_IDLE: next_c.mid = c.mid;
      endcase
    end
    if (load) begin
      next_c.act     = c.hold;
      next_c.pending = 1'b0;
    end

    // Selected camera nibble, override bit beating the pin, and routed aux levels
    next_c.cam_nib = cam_nib;
    for (int i = 0; i < AUX_N; i++) begin
      next_c.aux_lvl[i] = aux_route(aux_sel[2*i +: 2], aux_nib, main_lvl, sub_lvl,
                                    cam_nib);
    end

    // Enables before fault masking; the pin gates only the targeted display
    en[6] = main_lvl != 8'h00;
    en[5] = (sub_lvl != 8'h00) && (!target || en_pin);
    en[4] = (red != 4'h0) && (target || en_pin);
    en[3] = (green != 4'h0) && (target || en_pin);
    en[2] = (blue != 4'h0) && (target || en_pin);
    en[1] = cam_nib != 4'h0;
    en[0] = (aux_sel != 8'h00) || (aux_nib != 4'h0);
    next_c.en       = fault ? 7'h00 : en;
    next_c.shutdown = fault || (en == 7'h00);
    next_c.pump_en  = ~next_c.shutdown;

    // Dropout must stay present for the full delay before it counts
    if (!any_drop || step) begin
      next_c.drop_cnt = '0;
    end else begin
      next_c.drop_cnt = c.drop_cnt + CW'(1);
    end
    unique case (c.mode)
      PM_1X:   next_c.mode = step ? PM_15X : PM_1X;
      PM_15X:  next_c.mode = step ? PM_2X : PM_15X;
      PM_2X:   next_c.mode = PM_2X;
      default: next_c.mode = PM_1X;
    endcase
    if ((load && lvl_chg) || cam_fall || c.shutdown) begin
      next_c.mode = PM_1X;
    end
    if (opts[OPT_FORCE_2]) begin
      next_c.mode = PM_2X;
    end else if (opts[OPT_FORCE_15]) begin
      next_c.mode = PM_15X;
    end
  end

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      c <= '{mode: PM_1X, shutdown: 1'b1, default: '0};
    end else begin
      c <= next_c;
    end
  end

  assign MAIN_LEVEL_OUT  = c.act[SUB_MAIN];
  assign SUB_LEVEL_OUT   = c.act[SUB_SECONDARY];
  assign RED_LEVEL_OUT   = c.act[SUB_RED_GREEN][LO_NIB +: NIB_W];
  assign GREEN_LEVEL_OUT = c.act[SUB_RED_GREEN][HI_NIB +: NIB_W];
  assign BLUE_LEVEL_OUT  = c.act[SUB_BLUE_AUX][LO_NIB +: NIB_W];
  assign CAM_LEVEL_OUT   = c.cam_nib;
  assign AUX_LEVEL_OUT   = c.aux_lvl;
  assign {MAIN_EN_OUT, SUB_EN_OUT, RED_EN_OUT, GREEN_EN_OUT, BLUE_EN_OUT, CAM_EN_OUT,
          AUX_EN_OUT}    = c.en;
  assign SHUTDOWN_OUT    = c.shutdown;
  assign PUMP_EN_OUT     = c.pump_en;
  assign PUMP_MODE_OUT   = c.mode;

  // Checks on the system clock; the acknowledge check uses the bus clock
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);

  a_main_bank_off: assert property (c.act[SUB_MAIN] == 8'h00 |=> !MAIN_EN_OUT)
    else $error("main bank enabled with zero level");
  a_red_zero_off: assert property (c.act[SUB_RED_GREEN][LO_NIB +: NIB_W] == 4'h0
                                   |=> !RED_EN_OUT)
    else $error("red enabled with zero level");
  a_rgb_pin_gate: assert property (!opts[OPT_TARGET] && !c.pin_s2[P_EN]
                                   |=> !(RED_EN_OUT || GREEN_EN_OUT || BLUE_EN_OUT))
    else $error("rgb lit while its enable pin is low");
  a_sub_pin_gate: assert property (opts[OPT_TARGET] && !c.pin_s2[P_EN] |=> !SUB_EN_OUT)
    else $error("secondary lit while its enable pin is low");
  a_sub_pin_free: assert property (!opts[OPT_TARGET] && !fault &&
                                   c.act[SUB_SECONDARY] != 8'h00 |=> SUB_EN_OUT)
    else $error("untargeted secondary gated by enable pin");
  a_cam_high_pick: assert property (opts[OPT_CAM_OVR] ##1 1'b1
                                    |-> CAM_LEVEL_OUT == $past(c.act[SUB_CAMERA][HI_NIB +: NIB_W]))
    else $error("override does not pick camera high nibble");
  a_aux_all_zero: assert property (c.act[SUB_AUX_SEL] == 8'h00 &&
                                   c.act[SUB_BLUE_AUX][HI_NIB +: NIB_W] == 4'h0 |=> !AUX_EN_OUT)
    else $error("aux bank enabled with zero data");
  a_fault_off: assert property (fault |=> SHUTDOWN_OUT && !PUMP_EN_OUT && c.en == 7'h00)
    else $error("fault did not disable sources and pump");
  a_force_double: assert property (opts[OPT_FORCE_2] |=> PUMP_MODE_OUT == PM_2X)
    else $error("force bit did not hold double mode");
  a_cam_fall_1x: assert property (cam_fall && !opts[OPT_FORCE_2] && !opts[OPT_FORCE_15]
                                  |=> PUMP_MODE_OUT == PM_1X)
    else $error("camera pin fall did not restore 1x");
  a_step_delay: assert property ((PUMP_MODE_OUT == PM_1X && !opts[OPT_FORCE_15]) ##1
                                 (PUMP_MODE_OUT == PM_15X) |-> $past(c.drop_cnt) == DROP_LAST)
    else $error("pump stepped before dropout delay");
  a_stop_load: assert property (load |=> c.act == $past(c.hold) && !c.pending)
    else $error("stop did not transfer holding bytes");
  a_ack_only: assert property (@(posedge SCL_CLK_IN) disable iff (!link_rst_n)
                               SDA_OE_OUT |-> l.bit_cnt == ACK_BIT && l.ack_pend)
    else $error("data line driven outside acknowledge");

  c_load_seen: cover property (load && lvl_chg);
  c_pump_double: cover property (PUMP_MODE_OUT == PM_15X ##1 PUMP_MODE_OUT == PM_2X);
  c_cam_fall: cover property (cam_fall && PUMP_MODE_OUT != PM_1X);

endmodule

//--- common/lsc_pkg.sv
// Constants and types shared by the LED driver serial control block.
// Assumes a 100 MHz system clock and a two-wire link clocked by its own master.
package lsc_pkg;

  // Link framing
  localparam logic [6:0] SLAVE_ADDR = 7'h1B;  // Fixed slave address 0011011
  localparam logic       WRITE_BIT  = 1'h0;
  localparam logic [3:0] LAST_BIT   = 4'h7;   // Count of the eighth data bit
  localparam logic [3:0] ACK_BIT    = 4'h8;   // Count of the acknowledge clock

  // Sub-address codes, also the indices of the data registers
  localparam logic [2:0] SUB_NONE      = 3'h0;
  localparam logic [2:0] SUB_RED_GREEN = 3'h1;
  localparam logic [2:0] SUB_BLUE_AUX  = 3'h2;
  localparam logic [2:0] SUB_MAIN      = 3'h3;
  localparam logic [2:0] SUB_SECONDARY = 3'h4;
  localparam logic [2:0] SUB_AUX_SEL   = 3'h5;
  localparam logic [2:0] SUB_CAMERA    = 3'h6;
  localparam logic [2:0] SUB_OPTIONS   = 3'h7;

  // Nibble fields
  localparam int NIB_W  = 4;
  localparam int LO_NIB = 0;
  localparam int HI_NIB = 4;

  // Options register bits
  localparam int OPT_TARGET    = 1;  // enable_pin_target_bit
  localparam int OPT_CAM_OVR   = 2;  // camera_override_bit
  localparam int OPT_DROP_MASK = 3;  // rgb_aux4_dropout_mask
  localparam int OPT_FORCE_15  = 6;  // force_threehalves_pump
  localparam int OPT_FORCE_2   = 7;  // force_double_pump

  // Auxiliary source codes, two bits per output from the LSB upward
  localparam logic [1:0] AUXSRC_AUX  = 2'h0;
  localparam logic [1:0] AUXSRC_MAIN = 2'h1;
  localparam logic [1:0] AUXSRC_SEC  = 2'h2;
  localparam logic [1:0] AUXSRC_CAM  = 2'h3;
  localparam int         AUX_N       = 4;

  // Dropout inputs: one per current source; red 6, green 7, blue 8, aux4 16
  localparam int          N_SOURCES  = 17;
  localparam logic [16:0] DROP_MASKABLE = 17'h101C0;

  // Pin synchroniser lanes
  localparam int P_SCL = 5;
  localparam int P_SDA = 4;
  localparam int P_OT  = 3;
  localparam int P_RF  = 2;
  localparam int P_CAM = 1;
  localparam int P_EN  = 0;
  localparam int N_PINS = 6;

  // Dropout qualification time
  localparam int DROP_DELAY_US  = 400;
  localparam int CLK_MHZ        = 100;
  localparam int DROP_DELAY_DEF = DROP_DELAY_US * CLK_MHZ;

  typedef enum logic [1:0] {PM_1X, PM_15X, PM_2X} lsc_pump_t;
  typedef enum logic [1:0] {LK_ADDR, LK_SUB, LK_DATA, LK_IDLE} lsc_kind_t;

endpackage

//--- dv/lsc_bus_master.sv
// Bus master model that writes the LED driver over its two-wire link.
// Assumes the bench resolves SDA with a pull-up from sda_low_out and the slave.
module lsc_bus_master (
  output logic      scl_out,
  output logic      sda_low_out,
  input  wire logic sda_in
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 40;  // Half of the 80 ns link clock
  localparam int QTR  = 20;
  localparam int SKEW = 3;   // Keeps link edges off the system clock edges

  // Link clock stands high and SDA is released outside frames
  initial begin
    scl_out     = 1'h1;
    sda_low_out = 1'h0;
  end

  // Start: SDA falls with SCL high; wide margins suit the slave's synchroniser
  task automatic start();
    #(HALF + SKEW) sda_low_out = 1'h1;
    #HALF scl_out = 1'h0;
    #QTR;
  endtask

  // One byte MSB first, then SDA released so the slave can acknowledge
  task automatic put(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low_out = ~d[i];
      #QTR scl_out = 1'h1;
      #HALF scl_out = 1'h0;
      #QTR;
    end
    sda_low_out = 1'h0;
    #QTR scl_out = 1'h1;
    #QTR ack = (sda_in === 1'h0);
    #QTR scl_out = 1'h0;
    #QTR;
  endtask

  // Stop: SDA rises with SCL high, leaving the bus idle high
  task automatic stop();
    sda_low_out = 1'h1;
    #QTR scl_out = 1'h1;
    #HALF sda_low_out = 1'h0;
    #HALF;
  endtask
endmodule

//--- dv/led_driver_serial_control_test.sv
// Self-checking bench for the LED driver serial control block.
// Assumes lsc_pkg and the bus master model are compiled first.
module led_driver_serial_control_test import lsc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned DLY = 20;  // Short dropout delay keeps the run brief
  localparam int LIMIT = 60000;
  logic CLK_IN, NRST_IN, DISPLAY_EN_IN, CAM_SEL_IN, OVERTEMP_IN, REF_FAULT_IN;
  logic [N_SOURCES-1:0] DROPOUT_IN;
  logic SCL_CLK_IN, sda_low, ack, SDA_DATA_OUT, SDA_OE_OUT, MAIN_EN_OUT, SUB_EN_OUT;
  logic RED_EN_OUT, GREEN_EN_OUT, BLUE_EN_OUT, CAM_EN_OUT, AUX_EN_OUT, PUMP_EN_OUT;
  logic SHUTDOWN_OUT;
  logic [7:0] MAIN_LEVEL_OUT, SUB_LEVEL_OUT;
  logic [NIB_W-1:0] RED_LEVEL_OUT, GREEN_LEVEL_OUT, BLUE_LEVEL_OUT, CAM_LEVEL_OUT;
  logic [AUX_N-1:0][7:0] AUX_LEVEL_OUT;
  lsc_pump_t PUMP_MODE_OUT;
  wire logic SDA_IN;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;

  // Open-drain SDA with pull-up: low when either party pulls it
  assign SDA_IN = ~(sda_low | SDA_OE_OUT);

  lsc_led_serial_ctrl #(.DROP_DELAY_CYC(DLY)) dut_u (
    .CLK_IN, .NRST_IN, .SCL_CLK_IN, .SDA_IN, .SDA_DATA_OUT, .SDA_OE_OUT,
    .DISPLAY_EN_IN, .CAM_SEL_IN, .OVERTEMP_IN, .REF_FAULT_IN, .DROPOUT_IN,
    .MAIN_LEVEL_OUT, .SUB_LEVEL_OUT, .RED_LEVEL_OUT, .GREEN_LEVEL_OUT,
    .BLUE_LEVEL_OUT, .CAM_LEVEL_OUT, .AUX_LEVEL_OUT, .MAIN_EN_OUT, .SUB_EN_OUT,
    .RED_EN_OUT, .GREEN_EN_OUT, .BLUE_EN_OUT, .CAM_EN_OUT, .AUX_EN_OUT,
    .PUMP_EN_OUT, .SHUTDOWN_OUT, .PUMP_MODE_OUT
  );
  lsc_bus_master bus_u (.scl_out(SCL_CLK_IN), .sda_low_out(sda_low), .sda_in(SDA_IN));

  // 100 MHz system clock
  initial begin
    CLK_IN = 1'h0;
    forever #5 CLK_IN = ~CLK_IN;
  end

  // Hang guard: a stuck handshake still reaches the verdict
  always @(posedge CLK_IN) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      $display("mismatch timeout expected end seen hang");
      complete_run();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge CLK_IN);
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // Start and own address with the write bit
  task automatic open_w();
    bus_u.start();
    bus_u.put({SLAVE_ADDR, WRITE_BIT}, ack);
    chk("addr ack", 1, ack);
  endtask

  task automatic pair(input logic [7:0] sub, input logic [7:0] d);
    bus_u.put(sub, ack);
    chk("sub ack", 1, ack);
    bus_u.put(d, ack);
    chk("data ack", 1, ack);
  endtask

  // Load needs a few cycles after stop, so settle before looking
  task automatic wr(input logic [7:0] sub, input logic [7:0] d);
    open_w();
    pair(sub, d);
    bus_u.stop();
    cyc(6);
  endtask

  task automatic t_reset();
    chk("shutdown", 1, SHUTDOWN_OUT);
    chk("pump en", 0, PUMP_EN_OUT);
    chk("mode", PM_1X, PUMP_MODE_OUT);
    chk("main", 0, MAIN_LEVEL_OUT);
    chk("sda oe", 0, SDA_OE_OUT);
    chk("sda data", 0, SDA_DATA_OUT);
    $display("test reset done");
  endtask

  // Packing, upper sub-address bits ignored, code zero stores nowhere
  task automatic t_regs();
    wr(8'h01, 8'hA5);
    chk("red", 4'h5, RED_LEVEL_OUT);
    chk("green", 4'hA, GREEN_LEVEL_OUT);
    wr(8'hFA, 8'h3C);
    chk("blue", 4'hC, BLUE_LEVEL_OUT);
    wr(8'h03, 8'h80);
    chk("main", 8'h80, MAIN_LEVEL_OUT);
    chk("shutdown", 0, SHUTDOWN_OUT);
    wr(8'hFC, 8'h41);
    chk("sub", 8'h41, SUB_LEVEL_OUT);
    wr(8'h08, 8'h77);
    chk("main", 8'h80, MAIN_LEVEL_OUT);
    open_w();
    pair(8'h03, 8'h55);
    cyc(6);
    chk("main held", 8'h80, MAIN_LEVEL_OUT);
    bus_u.stop();
    cyc(6);
    chk("main load", 8'h55, MAIN_LEVEL_OUT);
    $display("test regs done");
  endtask

  // Read bit or foreign address: no acknowledge and nothing stored
  task automatic t_addr();
    logic [7:0] bad [2] = '{{SLAVE_ADDR, 1'h1}, {SLAVE_ADDR ^ 7'h01, WRITE_BIT}};
    foreach (bad[i]) begin
      bus_u.start();
      bus_u.put(bad[i], ack);
      chk("bad addr ack", 0, ack);
      bus_u.put(8'h03, ack);
      bus_u.put(8'h11, ack);
      chk("ignored ack", 0, ack);
      bus_u.stop();
      cyc(6);
      chk("main", 8'h55, MAIN_LEVEL_OUT);
    end
    $display("test addr done");
  endtask

  task automatic t_enable();
    DISPLAY_EN_IN = 1'h0;
    cyc(4);
    chk("red en", 0, RED_EN_OUT);
    chk("blue en", 0, BLUE_EN_OUT);
    chk("sub en", 1, SUB_EN_OUT);
    DISPLAY_EN_IN = 1'h1;
    cyc(4);
    chk("red en", 1, RED_EN_OUT);
    wr(8'h07, 8'h02);
    DISPLAY_EN_IN = 1'h0;
    cyc(4);
    chk("sub en", 0, SUB_EN_OUT);
    chk("red en", 1, RED_EN_OUT);
    DISPLAY_EN_IN = 1'h1;
    cyc(4);
    chk("sub en", 1, SUB_EN_OUT);
    wr(8'h07, 8'h00);
    $display("test enable done");
  endtask

  task automatic t_cam();
    wr(8'h06, 8'h93);
    chk("cam lo", 4'h3, CAM_LEVEL_OUT);
    chk("cam en", 1, CAM_EN_OUT);
    CAM_SEL_IN = 1'h1;
    cyc(4);
    chk("cam hi", 4'h9, CAM_LEVEL_OUT);
    CAM_SEL_IN = 1'h0;
    wr(8'h07, 8'h04);
    chk("cam ovr", 4'h9, CAM_LEVEL_OUT);
    wr(8'h07, 8'h00);
    $display("test cam done");
  endtask

  // Aux outputs 1..4 routed to aux, main, secondary and camera
  task automatic t_aux();
    logic [7:0] ex [4] = '{8'h03, 8'h55, 8'h41, 8'h03};
    wr(8'h05, 8'hE4);
    foreach (ex[i]) chk("aux level", ex[i], AUX_LEVEL_OUT[i]);
    chk("aux en", 1, AUX_EN_OUT);
    $display("test aux done");
  endtask

  task automatic t_fault();
    OVERTEMP_IN = 1'h1;
    cyc(4);
    chk("main en", 0, MAIN_EN_OUT);
    chk("pump en", 0, PUMP_EN_OUT);
    OVERTEMP_IN = 1'h0;
    cyc(4);
    chk("main en", 1, MAIN_EN_OUT);
    REF_FAULT_IN = 1'h1;
    cyc(4);
    chk("sub en", 0, SUB_EN_OUT);
    chk("pump en", 0, PUMP_EN_OUT);
    REF_FAULT_IN = 1'h0;
    cyc(4);
    chk("pump en", 1, PUMP_EN_OUT);
    $display("test fault done");
  endtask

  task automatic t_pump();
    DROPOUT_IN = 17'h00001;
    cyc(15);
    chk("mode early", PM_1X, PUMP_MODE_OUT);
    cyc(15);
    chk("mode", PM_15X, PUMP_MODE_OUT);
    cyc(25);
    chk("mode", PM_2X, PUMP_MODE_OUT);
    DROPOUT_IN = 17'h00000;
    wr(8'h03, 8'h81);
    chk("mode upd", PM_1X, PUMP_MODE_OUT);
    DROPOUT_IN = 17'h00001;
    cyc(30);
    DROPOUT_IN = 17'h00000;
    CAM_SEL_IN = 1'h1;
    cyc(4);
    CAM_SEL_IN = 1'h0;
    cyc(4);
    chk("mode cam", PM_1X, PUMP_MODE_OUT);
    wr(8'h07, 8'h08);
    DROPOUT_IN = DROP_MASKABLE;
    cyc(40);
    chk("mode mask", PM_1X, PUMP_MODE_OUT);
    DROPOUT_IN = 17'h00000;
    wr(8'h07, 8'hC0);
    chk("force 2x", PM_2X, PUMP_MODE_OUT);
    wr(8'h07, 8'h40);
    chk("force 1.5x", PM_15X, PUMP_MODE_OUT);
    wr(8'h07, 8'h00);
    $display("test pump done");
  endtask

  // Bank disables, then everything zero gives shutdown
  task automatic t_off();
    wr(8'h01, 8'hA0);
    chk("red en", 0, RED_EN_OUT);
    chk("green en", 1, GREEN_EN_OUT);
    open_w();
    pair(8'h03, 8'h00);
    pair(8'h04, 8'h00);
    pair(8'h01, 8'h00);
    pair(8'h06, 8'h00);
    pair(8'h05, 8'h00);
    bus_u.stop();
    cyc(6);
    chk("main en", 0, MAIN_EN_OUT);
    chk("sub en", 0, SUB_EN_OUT);
    chk("cam en", 0, CAM_EN_OUT);
    chk("aux en", 1, AUX_EN_OUT);
    wr(8'h02, 8'h00);
    chk("aux en", 0, AUX_EN_OUT);
    chk("shutdown", 1, SHUTDOWN_OUT);
    chk("pump en", 0, PUMP_EN_OUT);
    $display("test off done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence: reset for two cycles, let synchronisers fill, run tests
  initial begin
    NRST_IN = 1'h0;
    DISPLAY_EN_IN = 1'h1;
    CAM_SEL_IN = 1'h0;
    OVERTEMP_IN = 1'h0;
    REF_FAULT_IN = 1'h0;
    DROPOUT_IN = 17'h00000;
    cyc(2);
    NRST_IN = 1'h1;
    cyc(1);
    t_reset();
    cyc(3);
    t_regs();
    t_addr();
    t_enable();
    t_cam();
    t_aux();
    t_fault();
    t_pump();
    t_off();
    complete_run();
  end
endmodule
